// *** inc/acf_pkg.sv ***
// Overview of operation
// - Conversion clock period is system period times divider-plus-one
// - Five-bit divider sits in register bits 7:3
// - Alignment bit 2: zero right, one left
// - Alignment honoured only in ten-bit mode
// - Resolution bit 1: zero ten-bit, one eight-bit
// - Bit 0 selects gain: zero half, one unity
package acf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ACF_CONFIG_ADDR  = 8'hbc;
  localparam logic [7:0] ACF_CONFIG_RESET = 8'hf9;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int ACF_DIV_LSB   = 3;
  localparam int ACF_DIV_MSB   = 7;
  localparam int ACF_DIV_W     = 5;
  localparam int ACF_ALIGN_BIT = 2;
  localparam int ACF_EIGHT_BIT = 1;
  localparam int ACF_GAIN_BIT  = 0;

  // ****************************************************************
  // Result formatting
  // ****************************************************************
  localparam int ACF_RES_W  = 10;
  localparam int ACF_BYTE_W = 8;
  localparam logic [ACF_DIV_W-1:0] ACF_DIV_MIN_MPC = 5'h01;

endpackage : acf_pkg

// *** rtl/acf_clk_div.sv ***
`timescale 1ns/100ps
module acf_clk_div #(
  parameter int DIV_W = 5
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire              at_zero = (cnt_q == '0);

  // Reload at zero so a new divider takes effect on the next period
  assign cnt_d = at_zero ? div : cnt_q - 1'b1;
  assign tick  = at_zero & ce;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : acf_clk_div

// *** rtl/acf_config.sv ***
`timescale 1ns/100ps
module acf_config #(
  parameter int RES_W = acf_pkg::ACF_RES_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  output logic                  sfr_hit,
  input  wire logic             mem_power_ctrl_en,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_result,
  output logic                  conv_clk_en,
  output logic      [4:0]       conv_clk_divider,
  output logic                  result_left_align,
  output logic                  eight_bit_mode_en,
  output logic                  input_gain_sel,
  output logic                  div_setting_err,
  output logic      [7:0]       result_high_reg,
  output logic      [7:0]       result_low_reg,
  output logic                  result_valid
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Register and read data
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Captured result
  logic [7:0] res_hi_q;
  logic [7:0] res_hi_d;
  logic [7:0] res_lo_q;
  logic [7:0] res_lo_d;
  logic       res_vld_q;

  // Status
  logic       err_q;
  logic       err_d;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // A single address; every other access is left to the rest of the bus
  wire cfg_sel = (sfr_addr == acf_pkg::ACF_CONFIG_ADDR);
  wire cfg_wr  = cfg_sel & sfr_wr;
  wire cfg_rd  = cfg_sel & sfr_rd;
  wire cfg_ld  = ce & cfg_wr;

  assign sfr_hit = cfg_sel & (sfr_rd | sfr_wr);

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  // Whole byte written at once; all fields are read-write
  assign cfg_d = sfr_wdata;

  // Reset gives the slowest clock, ten-bit, right aligned, unity gain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q <= acf_pkg::ACF_CONFIG_RESET;
    end else if (cfg_ld) begin
      cfg_q <= cfg_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped reads return zero so a shared read mux can OR them;
  // a read beside a write in one cycle still sees the old byte
  assign rdata_d = cfg_rd ? cfg_q : 8'h00;

  // Registered, so the answer lags the strobe by one edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [4:0] div_f   = cfg_q[acf_pkg::ACF_DIV_MSB:acf_pkg::ACF_DIV_LSB];
  wire       eight_f = cfg_q[acf_pkg::ACF_EIGHT_BIT];
  wire       align_f = cfg_q[acf_pkg::ACF_ALIGN_BIT];
  // Alignment masked in eight-bit mode for the output and formatter alike; register reads keep the raw bit
  wire       left_f  = align_f & ~eight_f;

  // Divider exported for the converter's own timing checks
  assign conv_clk_divider  = div_f;
  assign eight_bit_mode_en = eight_f;
  assign result_left_align = left_f;
  // Gain select goes straight to the input amplifier
  assign input_gain_sel    = cfg_q[acf_pkg::ACF_GAIN_BIT];

  // ****************************************************************
  // Conversion clock enable
  // ****************************************************************
  // Tick is combinational so the converter sees it in the counted cycle
  acf_clk_div #(
    .DIV_W (acf_pkg::ACF_DIV_W)
  ) u_div (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .div   (div_f),
    .tick  (conv_clk_en)
  );

  // ****************************************************************
  // Divider setting flag
  // ****************************************************************
  // Flags a divider of zero while the power controller runs; the
  // converter may misbehave, the setting itself is still honoured
  assign err_d = mem_power_ctrl_en & (div_f < acf_pkg::ACF_DIV_MIN_MPC);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (ce) begin
      err_q <= err_d;
    end
  end

  // ****************************************************************
  // Result formatting
  // ****************************************************************
  // Ten-bit result, low justified: top two bits land in the high byte
  function automatic logic [15:0] acf_right(input logic [RES_W-1:0] r);
    return {{(16-RES_W){1'b0}}, r};
  endfunction : acf_right

  // Ten-bit result, high justified: the low byte keeps two bits
  function automatic logic [15:0] acf_left(input logic [RES_W-1:0] r);
    return {r, {(16-RES_W){1'b0}}};
  endfunction : acf_left

  // Eight-bit result is the top eight bits, low register only
  function automatic logic [15:0] acf_eight(input logic [RES_W-1:0] r);
    return {8'h00, r[RES_W-1 -: 8]};
  endfunction : acf_eight

  // Eight-bit mode overrides alignment
  function automatic logic [15:0] acf_format(input logic [RES_W-1:0] r,
                                             input logic eight,
                                             input logic left);
    logic [15:0] v;
    v = 16'h0000;
    if (eight) begin
      v = acf_eight(r);
    end else if (left) begin
      v = acf_left(r);
    end else begin
      v = acf_right(r);
    end
    return v;
  endfunction : acf_format

  // Fields taken at capture time; a later write leaves held data alone
  wire [15:0] fmt = acf_format(conv_result, eight_f, left_f);

  assign res_hi_d = fmt[15:8];
  assign res_lo_d = fmt[7:0];

  // ****************************************************************
  // Result capture
  // ****************************************************************
  // Data registers load only on a finished conversion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_hi_q <= 8'h00;
    end else if (ce && conv_done) begin
      res_hi_q <= res_hi_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_lo_q <= 8'h00;
    end else if (ce && conv_done) begin
      res_lo_q <= res_lo_d;
    end
  end

  // Valid rises on the capture edge itself and lasts one cycle per done pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_vld_q <= 1'b0;
    end else if (ce) begin
      res_vld_q <= conv_done;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign result_high_reg = res_hi_q;
  assign result_low_reg  = res_lo_q;
  assign result_valid    = res_vld_q;
  assign div_setting_err = err_q;

endmodule : acf_config

// *** test/acf_config_checker.sv ***
`timescale 1ns/100ps
module acf_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       conv_clk_en,
  input wire logic [4:0] conv_clk_divider,
  input wire logic       result_left_align,
  input wire logic       eight_bit_mode_en,
  input wire logic       input_gain_sel
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire wr_hit = ce && sfr_wr && sfr_addr == 8'hbc;
  wire rd_hit = ce && sfr_rd && sfr_addr == 8'hbc;
  sequence s_gap1; !conv_clk_en ##1 conv_clk_en; endsequence
  sequence s_quiet; !conv_clk_en [*8]; endsequence
  chk_div_field: assert property (wr_hit |=> conv_clk_divider == $past(sfr_wdata[7:3]))
    else $error("divider field wrong");
  chk_gain_bit: assert property (wr_hit |=> input_gain_sel == $past(sfr_wdata[0]))
    else $error("gain bit wrong");
  chk_mode_bit: assert property (wr_hit |=> eight_bit_mode_en == $past(sfr_wdata[1]))
    else $error("mode bit wrong");
  chk_align_on: assert property (wr_hit && sfr_wdata[2:1] == 2'h2 |=> result_left_align)
    else $error("left align missing");
  chk_align_off: assert property (eight_bit_mode_en |-> !result_left_align)
    else $error("align not ignored");
  chk_read_back: assert property (rd_hit |=> {sfr_rdata[7:3], sfr_rdata[1:0]} ==
    {$past(conv_clk_divider), $past(eight_bit_mode_en), $past(input_gain_sel)})
    else $error("read data wrong");
  // Needs ce held high, as the bench does while the divider is one
  chk_period_one: assert property (conv_clk_en && conv_clk_divider == 5'h01 &&
    $stable(conv_clk_divider) |=> s_gap1)
    else $error("period two wrong");
  chk_period_max: assert property (conv_clk_en && conv_clk_divider == 5'h1f &&
    $stable(conv_clk_divider) |=> s_quiet)
    else $error("long period cut short");
endmodule : acf_checker
bind acf_config acf_checker chk_i (.*);

// *** test/acf_config_tb_top.sv ***
`timescale 1ns/100ps
module acf_config_tb_top;
  logic       clock = 1'h0, rst = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
  logic       ce = 1'h1, mpc_en = 1'h0, conv_done = 1'h0;
  logic [9:0] conv_result = 10'h000;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  wire  [7:0] sfr_rdata, result_high_reg, result_low_reg;
  wire        sfr_hit, div_setting_err, result_valid;
  wire  [4:0] conv_clk_divider;
  wire        conv_clk_en, result_left_align, eight_bit_mode_en, input_gain_sel;
  int         n_fail = 0, n_compared = 0;
  acf_config DUT (.clock(clock), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .mem_power_ctrl_en(mpc_en), .conv_done(conv_done), .conv_result(conv_result),
    .conv_clk_en(conv_clk_en), .conv_clk_divider(conv_clk_divider),
    .result_left_align(result_left_align), .eight_bit_mode_en(eight_bit_mode_en),
    .input_gain_sel(input_gain_sel), .div_setting_err(div_setting_err),
    .result_high_reg(result_high_reg), .result_low_reg(result_low_reg),
    .result_valid(result_valid));
  // ********
  // Tasks
  // ********
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge clock);
    sfr_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(negedge clock);
    cmp("hit", {7'h00, a == 8'hbc}, {7'h00, sfr_hit});
    @(posedge clock);
    sfr_rd <= 1'h0;
    @(negedge clock);
    cmp("rdata", e, sfr_rdata);
  endtask : rd
  task automatic conv(input logic [9:0] r, input logic [7:0] eh, input logic [7:0] el);
    @(posedge clock);
    conv_result <= r;
    conv_done <= 1'h1;
    @(posedge clock);
    conv_done <= 1'h0;
    @(negedge clock);
    cmp("valid", 8'h01, {7'h00, result_valid});
    cmp("res_high", eh, result_high_reg);
    cmp("res_low", el, result_low_reg);
    @(negedge clock);
    cmp("valid_end", 8'h00, {7'h00, result_valid});
  endtask : conv
  // First pulse may end an old period, so time the next one
  task automatic per(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    do @(negedge clock); while (conv_clk_en !== 1'h1);
    do begin
      @(negedge clock);
      n++;
    end while (conv_clk_en !== 1'h1);
    cmp("period", e, n);
  endtask : per
  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial forever #10 clock = ~clock;
  initial begin
    #20000;
    n_fail++;
    print_verdict();
  end
  initial begin
    rst <= 1'h1;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    rd(8'hbc, 8'hf9);
    per(8'h20);
    wr(8'hbc, 8'h0c);
    rd(8'hbc, 8'h0c);
    cmp("fields", 8'h04, {5'h00, result_left_align, eight_bit_mode_en, input_gain_sel});
    per(8'h02);
    wr(8'hbd, 8'hff);
    rd(8'hbc, 8'h0c);
    rd(8'hbd, 8'h00);
    wr(8'hbc, 8'h07);
    rd(8'hbc, 8'h07);
    cmp("fields", 8'h03, {5'h00, result_left_align, eight_bit_mode_en, input_gain_sel});
    per(8'h01);
    conv(10'h2b5, 8'h00, 8'had);
    wr(8'hbc, 8'h0c);
    conv(10'h2b5, 8'had, 8'h40);
    wr(8'hbc, 8'h08);
    conv(10'h2b5, 8'h02, 8'hb5);
    cmp("fields", 8'h00, {5'h00, result_left_align, eight_bit_mode_en, input_gain_sel});
    @(posedge clock) mpc_en <= 1'h1;
    repeat (2) @(negedge clock);
    cmp("div_err", 8'h00, {7'h00, div_setting_err});
    wr(8'hbc, 8'h00);
    repeat (2) @(negedge clock);
    cmp("div_err", 8'h01, {7'h00, div_setting_err});
    @(posedge clock) mpc_en <= 1'h0;
    wr(8'hbc, 8'h10);
    @(posedge clock) ce <= 1'h0;
    wr(8'hbc, 8'hff);
    @(negedge clock);
    cmp("clk_en", 8'h00, {7'h00, conv_clk_en});
    @(posedge clock) ce <= 1'h1;
    rd(8'hbc, 8'h10);
    per(8'h03);
    @(posedge clock) rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    rd(8'hbc, 8'hf9);
    cmp("div_err", 8'h00, {7'h00, div_setting_err});
    print_verdict();
  end
endmodule : acf_config_tb_top
